// File: bench/alert_asserts.sv
// Concurrent checks on the alert output block ports
`timescale 1ns/10ps
module alert_asserts (
  input wire logic mclk, reset_n, avs_read, avs_write, avs_waitrequest, temp_measure_active,
  input wire logic [3:0] avs_address,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] avs_response,
  input wire logic [4:0] ext_led_count,
  input wire logic port_pin_two_o, port_pin_six_o, port_pin_five_o, port_pin_four_o,
  input wire logic port_pin_two_oe, port_pin_six_oe, port_pin_five_oe, port_pin_four_oe
);
  wire [3:0] oe = {port_pin_four_oe, port_pin_five_oe, port_pin_six_oe, port_pin_two_oe};
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  one_pin_a: assert property ($onehot0(oe)) else $error("alert on two pins");
  drive_low_a: assert property (!(port_pin_two_o | port_pin_six_o | port_pin_five_o | port_pin_four_o))
    else $error("alert pin driven high");
  temp_gap_a: assert property (temp_measure_active |-> !port_pin_six_oe)
    else $error("shared pin driven during measurement");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("slave answer late");
  rst_clean_a: assert property ($rose(reset_n) |-> oe == 4'h0 && avs_response == 2'h0)
    else $error("alert or response after reset");
  bad_addr_a: assert property (avs_read && avs_address > 4'h3 && !avs_waitrequest |-> avs_response == 2'h3)
    else $error("unmapped read not refused");
  good_addr_a: assert property ((avs_read || avs_write) && avs_address < 4'h4 && !avs_waitrequest
    |-> avs_response == 2'h0) else $error("mapped access refused");
  led_range_a: assert property (ext_led_count != 5'h0 && ext_led_count < 5'h11)
    else $error("led count out of range");
endmodule // alert_asserts
bind battery_alert_output alert_asserts CHK (.*);

// File: bench/alert_host.sv
// Host-side model that senses the alert pins through pull-ups
`timescale 1ns/10ps
module alert_host (
  input wire logic [3:0] oe,
  input wire logic gap,
  output logic [3:0] lvl,
  output logic six_filt
);
  logic six_held = 1'b1;
  // Host-side filter: hold the shared pin level across measurement gaps
  always @(oe[1] or gap) if (!gap) six_held = ~oe[1];
  assign six_filt = six_held;
  // A released pin reads the pull-up level, never the last driven value
  assign lvl = ~oe;
endmodule // alert_host

// File: bench/tb.sv
// Testbench: register access, flag masking and alert pin routing
`timescale 1ns/10ps
module tb;
  logic mclk = 0, reset_n = 0, avs_read = 0, avs_write = 0, relax_entry = 0, ocv_sample_taken = 0;
  logic charge_termination = 0, temp_measure_active = 0, six_filt;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, lvl;
  logic [31:0] avs_writedata = 32'h0, q;
  logic [15:0] status_flags = 16'h0;
  logic [7:0] state_of_charge = 8'h00, full_charge_threshold = 8'hff;
  wire [31:0] avs_readdata;
  wire [1:0] avs_response;
  wire [4:0] ext_led_count;
  wire avs_waitrequest, led_always_on, port_pin_two_o, port_pin_six_o, port_pin_five_o, port_pin_four_o;
  wire port_pin_two_oe, port_pin_six_oe, port_pin_five_oe, port_pin_four_oe;
  int errors = 0, total_checks = 0;
  int bits[11] = '{15, 14, 13, 12, 11, 10, 8, 4, 2, 1, 0};
  logic [9:0] pin_of_mode = {2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
  battery_alert_output DUT (.*);
  alert_host HOST (.oe({port_pin_four_oe, port_pin_five_oe, port_pin_six_oe, port_pin_two_oe}),
    .gap(temp_measure_active), .lvl(lvl), .six_filt(six_filt));
  always #5 mclk = ~mclk;
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; read data taken then
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= !w;
    do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'h0 && n < 50);
    if (n >= 50) begin errors++; print_verdict(); end
    q = avs_readdata;
    avs_write <= 1'h0; avs_read <= 1'h0;
  endtask
  task automatic pins(input logic [3:0] e);
    repeat (3) @(posedge mclk);
    @(negedge mclk) chk({28'h0, lvl}, {28'h0, e});
    @(posedge mclk);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'h1;
    bus(0, 4'h0, 0); chk(q, 32'h0);
    bus(0, 4'h1, 0); chk(q, 32'h0);
    bus(1, 4'h0, 32'hffff); bus(0, 4'h0, 0); chk(q, 32'hff97);
    bus(0, 4'h5, 0); chk({30'h0, avs_response}, 32'h3);
    $display("register test done");
    foreach (bits[i]) begin
      bus(1, 4'h0, 32'h1 << bits[i]);
      status_flags <= ~(16'h1 << bits[i]); pins(4'hf);
      status_flags <= 16'h1 << bits[i]; pins(4'he);
    end
    $display("mask test done");
    status_flags <= 16'h1; bus(1, 4'h0, 32'h1);
    for (int m = 0; m < 5; m++) begin
      bus(1, 4'h1, m); bus(0, 4'h3, 0); chk(q, {29'h0, pin_of_mode[2*m+:2], 1'h1});
      pins(~(4'h1 << pin_of_mode[2*m+:2]));
    end
    bus(1, 4'h1, 32'h2); temp_measure_active <= 1'h1; pins(4'hf);
    chk({31'h0, six_filt}, 32'h0);
    temp_measure_active <= 1'h0;
    bus(1, 4'h1, 32'h43); chk({27'h0, ext_led_count}, 32'h5); pins(4'hb);
    bus(1, 4'h1, 32'h94); chk({27'h0, ext_led_count}, 32'ha); pins(4'h7);
    bus(1, 4'h1, 32'h0);
    $display("routing test done");
    status_flags <= 16'h0; bus(1, 4'h0, 32'h80);
    ocv_sample_taken <= 1'h1; @(posedge mclk); ocv_sample_taken <= 1'h0; pins(4'he);
    relax_entry <= 1'h1; @(posedge mclk); relax_entry <= 1'h0; pins(4'hf);
    bus(1, 4'h0, 32'h200);
    charge_termination <= 1'h1; @(posedge mclk); charge_termination <= 1'h0; pins(4'he);
    full_charge_threshold <= 8'h32; state_of_charge <= 8'h28; pins(4'hf);
    state_of_charge <= 8'h3c; pins(4'he);
    $display("flag source test done");
    print_verdict();
  end
endmodule // tb

// File: hdl/alert_out_regs.vh
// Register map, field positions and constants of the battery alert output block
`ifndef ALERT_OUT_REGS_VH
`define ALERT_OUT_REGS_VH

`define ADDR_ALERT_ENABLE_MASK 4'h0
`define ADDR_DISPLAY_LINK_CONFIG 4'h1
`define ADDR_FLAGS_WORD 4'h2
`define ADDR_ALERT_STATUS 4'h3
`define ADDR_W 4

`define MASK_RESET 16'h0000
`define CONFIG_RESET 8'h00
`define MASK_WRITABLE 16'hff97

`define MODE_LSB 0
`define MODE_MSB 2
`define LED_ON_BIT 3
`define LED_COUNT_LSB 4
`define LED_COUNT_MSB 7

`define MODE_NO_LED 3'h0
`define MODE_SINGLE_LED 3'h1
`define MODE_FOUR_LED 3'h2
`define MODE_EXT_TWO_WIRE 3'h3
`define MODE_EXT_ONE_WIRE 3'h4

`define PIN_TWO 2'h0
`define PIN_SIX 2'h1
`define PIN_FIVE 2'h2
`define PIN_FOUR 2'h3

`define BIT_OVER_TEMP_CHG 15
`define BIT_OVER_TEMP_DSG 14
`define BIT_PACK_V_HIGH 13
`define BIT_PACK_V_LOW 12
`define BIT_CHARGE_INHIBIT 11
`define BIT_CHARGE_DISALLOWED 10
`define BIT_FULL_CHARGE 9
`define BIT_CHARGE_ALLOWED 8
`define BIT_OCV_DONE 7
`define BIT_RSVD_HI 6
`define BIT_RSVD_LO 5
`define BIT_CONDITION_FLAG 4
`define BIT_RSVD_MID 3
`define BIT_REM_CAP_ALARM 2
`define BIT_END_OF_DISCHARGE 1
`define BIT_DISCHARGING 0

`define FC_THRESHOLD_NONE 8'hff

`endif

// File: hdl/battery_alert_output.v
// Battery alert output: flag sources, alert mask, pin routing and Avalon-MM slave
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "alert_out_regs.vh"

module battery_alert_output #(
  parameter FLAG_W = 16
) (
  input wire mclk,
  input wire reset_n,
  input wire [`ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire [1:0] avs_response,
  input wire [FLAG_W-1:0] status_flags,
  input wire relax_entry,
  input wire ocv_sample_taken,
  input wire charge_termination,
  input wire [7:0] state_of_charge,
  input wire [7:0] full_charge_threshold,
  input wire temp_measure_active,
  output wire port_pin_two_o,
  output wire port_pin_two_oe,
  output wire port_pin_six_o,
  output wire port_pin_six_oe,
  output wire port_pin_five_o,
  output wire port_pin_five_oe,
  output wire port_pin_four_o,
  output wire port_pin_four_oe,
  output wire [4:0] ext_led_count,
  output wire led_always_on
);

  reg [15:0] mask_q;
  reg [7:0] config_q;
  reg ocv_done_q;
  reg full_charge_q;
  reg alert_q;
  reg [31:0] rdata_q;
  reg ack_q;
  reg [1:0] resp_q;
  reg [15:0] flags_word;
  reg [3:0] pin_drive_low;
  wire alert_now;
  wire [2:0] mode;
  wire [1:0] pin_sel;
  wire access;
  wire mapped;
  wire [31:0] mask_merged;
  wire [31:0] config_merged;

  function [1:0] pin_of_mode;
    input [2:0] m;
    begin
      case (m)
        `MODE_NO_LED: pin_of_mode = `PIN_TWO;
        `MODE_SINGLE_LED: pin_of_mode = `PIN_TWO;
        `MODE_FOUR_LED: pin_of_mode = `PIN_SIX;
        `MODE_EXT_TWO_WIRE: pin_of_mode = `PIN_FIVE;
        `MODE_EXT_ONE_WIRE: pin_of_mode = `PIN_FOUR;
        default: pin_of_mode = `PIN_TWO;
      endcase
    end
  endfunction

  function [31:0] merge_bytes;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer i;
    begin
      merge_bytes = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge_bytes[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  assign mask_merged = merge_bytes({16'h0000, mask_q}, avs_writedata, avs_byteenable);
  assign config_merged = merge_bytes({24'h000000, config_q}, avs_writedata, avs_byteenable);
  assign mode = config_q[`MODE_MSB:`MODE_LSB];
  assign pin_sel = pin_of_mode(mode);
  // Config code 0 is reserved; count reported as given, 1 + code
  assign ext_led_count = {1'b0, config_q[`LED_COUNT_MSB:`LED_COUNT_LSB]} + 5'h01;
  assign led_always_on = config_q[`LED_ON_BIT];

  // Two flags are produced here and reserved bits 6, 5 and 3 are cleared; the rest come from the gauge core
  always @* begin
    flags_word = status_flags;
    flags_word[`BIT_OCV_DONE] = ocv_done_q;
    flags_word[`BIT_FULL_CHARGE] = full_charge_q;
    flags_word[`BIT_RSVD_HI:`BIT_RSVD_LO] = 2'h0;
    flags_word[`BIT_RSVD_MID] = 1'b0;
  end

  assign alert_now = |(flags_word & mask_q);

  // Bus access completes one cycle after it is seen
  assign access = (avs_read | avs_write) & ~ack_q;
  assign mapped = (avs_address == `ADDR_ALERT_ENABLE_MASK) | (avs_address == `ADDR_DISPLAY_LINK_CONFIG) |
                  (avs_address == `ADDR_FLAGS_WORD) | (avs_address == `ADDR_ALERT_STATUS);
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
  assign avs_response = resp_q;

  always @(posedge mclk) begin
    if (!reset_n) begin
      mask_q <= `MASK_RESET;
      config_q <= `CONFIG_RESET;
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      resp_q <= 2'h0;
    end else begin
      ack_q <= access;
      if (access) begin
        resp_q <= mapped ? 2'h0 : 2'h3;
        rdata_q <= 32'h00000000;
        if (avs_read) begin
          case (avs_address)
            `ADDR_ALERT_ENABLE_MASK: rdata_q <= {16'h0000, mask_q};
            `ADDR_DISPLAY_LINK_CONFIG: rdata_q <= {24'h000000, config_q};
            `ADDR_FLAGS_WORD: rdata_q <= {16'h0000, flags_word};
            `ADDR_ALERT_STATUS: rdata_q <= {29'h00000000, pin_sel, alert_q};
            default: rdata_q <= 32'h00000000;
          endcase
        end
        if (avs_write && avs_address == `ADDR_ALERT_ENABLE_MASK) begin
          // Reserved mask bits stay zero
          mask_q <= mask_merged[15:0] & `MASK_WRITABLE;
        end
        if (avs_write && avs_address == `ADDR_DISPLAY_LINK_CONFIG) begin
          // Codes 43/93/44/94 land as mode plus LED count fields
          config_q <= config_merged[7:0];
        end
      end
    end
  end

  // Sample-done: relax entry clears; a sample in the same cycle wins
  always @(posedge mclk) begin
    if (!reset_n) begin
      ocv_done_q <= 1'b0;
    end else if (ocv_sample_taken) begin
      ocv_done_q <= 1'b1;
    end else if (relax_entry) begin
      ocv_done_q <= 1'b0;
    end
  end

  // Full charge: with threshold 0xff, set by charge termination and held while threshold stays 0xff; otherwise state of charge above threshold
  always @(posedge mclk) begin
    if (!reset_n) begin
      full_charge_q <= 1'b0;
    end else if (full_charge_threshold == `FC_THRESHOLD_NONE) begin
      if (charge_termination) begin
        full_charge_q <= 1'b1;
      end
    end else begin
      full_charge_q <= state_of_charge > full_charge_threshold;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= alert_now;
    end
  end

  // Open-drain style drive; in four-LED mode the temp pin is pulled low on alert except while measuring
  always @* begin
    pin_drive_low = 4'h0;
    if (mode == `MODE_FOUR_LED) begin
      pin_drive_low[`PIN_SIX] = alert_q & ~temp_measure_active;
    end else begin
      pin_drive_low[pin_sel] = alert_q;
    end
  end

  assign port_pin_two_o = 1'b0;
  assign port_pin_two_oe = pin_drive_low[`PIN_TWO];
  assign port_pin_six_o = 1'b0;
  assign port_pin_six_oe = pin_drive_low[`PIN_SIX];
  assign port_pin_five_o = 1'b0;
  assign port_pin_five_oe = pin_drive_low[`PIN_FIVE];
  assign port_pin_four_o = 1'b0;
  assign port_pin_four_oe = pin_drive_low[`PIN_FOUR];

endmodule // battery_alert_output
